// ===== edge_sync.sv
`timescale 1ns/1ns
`default_nettype none
module edge_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    output logic rise_o
);

    typedef struct packed {
        logic [2:0] sh;
        logic level;
        logic rise;
    } sync_s;

    sync_s st_r;
    sync_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.sh = {st_r.sh[1:0], pin_i};
        st_nxt.rise = 1'b0;
        if (st_r.sh[1] == st_r.sh[2]) begin
            st_nxt.level = st_r.sh[2];
            st_nxt.rise = st_r.sh[2] & ~st_r.level;
        end
        if (rst_i) begin
            st_nxt = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        st_r <= st_nxt;
    end

    assign rise_o = st_r.rise;

    AST_RISE_AGREED: assert property (@(posedge clk_i) disable iff (rst_i) // R01
        rise_o |-> $past(st_r.sh[2]) && $past(st_r.sh[1]) && st_r.level)
        else $error("rc clock edge without agreeing stages");

endmodule
`default_nettype wire

// ===== wdt_counter.sv
`timescale 1ns/1ns
`default_nettype none
module watchdog_counter
    import watchdog_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic run_i,
    input wire logic clear_i,
    input wire logic pre_sel_i,
    input wire logic [3:0] post_sel_i,
    input wire logic [1:0] win_sel_i,
    output logic expire_o,
    output logic win_open_o,
    output logic [POST_W-1:0] post_cnt_o
);

    typedef struct packed {
        logic [6:0] pre;
        logic [POST_W-1:0] post;
    } cnt_s;

    cnt_s st_r;
    cnt_s st_nxt;
    logic [6:0] pre_last;
    logic [POST_W-1:0] post_last;
    logic [25:0] elapsed;
    logic [25:0] total;
    logic [2:0] close8;

    always_comb begin
        pre_last = pre_sel_i ? PRE_LAST_128 : PRE_LAST_32; // R02 R18
        post_last = POST_W'((16'h1 << post_sel_i) - 16'h1); // R03 R19
        case (win_sel_i) // R17
            2'h3: close8 = WIN_CLOSE_25;
            2'h2: close8 = WIN_CLOSE_375;
            2'h1: close8 = WIN_CLOSE_50;
            default: close8 = WIN_CLOSE_75;
        endcase
        if (pre_sel_i) begin
            elapsed = (26'(st_r.post) << PRE_SHIFT_128) | 26'(st_r.pre);
            total = (26'(post_last) + 26'h1) << PRE_SHIFT_128;
        end else begin
            elapsed = (26'(st_r.post) << PRE_SHIFT_32) | 26'(st_r.pre);
            total = (26'(post_last) + 26'h1) << PRE_SHIFT_32;
        end
    end

    assign expire_o = run_i & tick_i & (st_r.pre == pre_last)
                      & (st_r.post == post_last);
    assign win_open_o = 26'(elapsed << 3) >= 26'(total * 26'(close8));
    assign post_cnt_o = st_r.post;

    always_comb begin
        st_nxt = st_r;
        if (rst_i || clear_i || !run_i) begin
            st_nxt = '0; // R04
        end else if (tick_i) begin
            if (st_r.pre == pre_last) begin
                st_nxt.pre = 7'h00;
                st_nxt.post = (st_r.post == post_last) ? '0
                              : POST_W'(st_r.post + 1'b1);
            end else begin
                st_nxt.pre = 7'(st_r.pre + 1'b1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        st_r <= st_nxt;
    end

    AST_PRE_WRAP: assert property (@(posedge clk_i) disable iff (rst_i) // R02
        run_i && tick_i && !clear_i && st_r.pre == pre_last
        |=> st_r.pre == 7'h00)
        else $error("prescaler did not wrap at its limit");

    AST_CLEAR_ZERO: assert property (@(posedge clk_i) disable iff (rst_i) // R04
        clear_i |=> st_r.pre == 7'h00 && st_r.post == '0)
        else $error("scalers not cleared");

endmodule
`default_nettype wire

// ===== wdt_pkg.sv
package watchdog_pkg;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses, one word each)
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CFG_OFS = 8'h00;
    localparam logic [7:0] REG_RC_OFS = 8'h04;
    localparam logic [7:0] REG_CMD_OFS = 8'h08;
    localparam logic [7:0] REG_STAT_OFS = 8'h0c;

    // ----------------------------------------------------------------
    // Watchdog configuration word fields
    // ----------------------------------------------------------------
    localparam int CFG_W = 10;
    localparam int CFG_POST_LSB = 0;
    localparam int CFG_PRE_BIT = 4;
    localparam int CFG_WIN_OFF_BIT = 6;
    localparam int CFG_HWON_BIT = 7;
    localparam int CFG_WIN_LSB = 8;
    localparam logic [CFG_W-1:0] CFG_RST = 10'h35f;

    // ----------------------------------------------------------------
    // Reset control register fields
    // ----------------------------------------------------------------
    localparam int RC_IDLE_BIT = 2;
    localparam int RC_SLEEP_BIT = 3;
    localparam int RC_TO_BIT = 4;
    localparam int RC_SWEN_BIT = 5;
    localparam logic RC_SWEN_RST = 1'b0;
    localparam logic RC_TO_RST = 1'b0;

    // ----------------------------------------------------------------
    // Command register bits
    // ----------------------------------------------------------------
    localparam int CMD_CLEAR_BIT = 0;
    localparam int CMD_SLEEP_BIT = 1;
    localparam int CMD_IDLE_BIT = 2;
    localparam int CMD_EXIT_BIT = 3;

    // ----------------------------------------------------------------
    // Status register fields
    // ----------------------------------------------------------------
    localparam int STAT_RUN_BIT = 0;
    localparam int STAT_WIN_BIT = 1;
    localparam int STAT_PS_LSB = 2;
    localparam int STAT_CNT_LSB = 16;

    // ----------------------------------------------------------------
    // Scaler figures
    // ----------------------------------------------------------------
    localparam int RC_OSC_NOM_HZ = 32000;
    localparam int CLK_HZ = 100000000;
    localparam logic [6:0] PRE_LAST_32 = 7'h1f;
    localparam logic [6:0] PRE_LAST_128 = 7'h7f;
    localparam int PRE_SHIFT_32 = 5;
    localparam int PRE_SHIFT_128 = 7;
    localparam int POST_W = 15;
    // Window closed part in eighths of the period
    localparam logic [2:0] WIN_CLOSE_25 = 3'h6;
    localparam logic [2:0] WIN_CLOSE_375 = 3'h5;
    localparam logic [2:0] WIN_CLOSE_50 = 3'h4;
    localparam logic [2:0] WIN_CLOSE_75 = 3'h2;

    typedef enum logic [1:0] {
        PS_RUN,
        PS_SLEEP,
        PS_IDLE
    } ps_e;

endpackage

// ===== windowed_watchdog_timer.sv
//
// Overview of operation
// R01 - Counter runs from the low power RC clock; enabling forces it on.
// R02 - The 32 kHz clock feeds a prescaler dividing by 32 or 128.
// R03 - A postscaler divides further by one of 16 ratios, 1:1 to 1:32768.
// R04 - Every device reset clears the counter, prescaler and postscaler.
// R05 - A completed clock switch clears the counter and both scalers.
// R06 - Entering Sleep or Idle clears the counter and both scalers.
// R07 - Leaving Sleep or Idle clears the counter and both scalers.
// R08 - The clear instruction in normal execution clears counter and scalers.
// R09 - An enabled watchdog keeps counting during Sleep and Idle.
// R10 - A time-out in Sleep or Idle wakes the core, no reset.
// R11 - Software clears the Sleep and Idle flags after wake-up.
// R12 - Hardware always-on bit set keeps the watchdog running regardless.
// R13 - With always-on clear, the software enable bit decides running.
// R14 - Every device reset clears the software enable bit.
// R15 - The time-out flag is sticky; only software clears it. The code also clears it on rst_i (RC_TO_RST).
// R16 - Window disable bit clear selects windowed mode.
// R17 - Window select picks 25, 37.5, 50 or 75 percent of the period.
// R18 - Prescale select one gives 1:128, zero gives 1:32.
// R19 - Postscale field is a power of two: 0000 is 1:1, 1111 1:32768.
// R20 - A time-out in normal execution resets the device, sets the flag.
// R21 - A windowed clear before the window opens resets the device.
//
`timescale 1ns/1ns
`default_nettype none
module windowed_watchdog_timer
    import watchdog_pkg::*;
#(
    parameter int ADR_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic low_power_rc_osc_i,
    input wire logic clk_switch_done_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic device_reset_o,
    output logic wake_o,
    output logic low_power_rc_osc_en_o
);

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    if (ADR_W < 4 || ADR_W > 8) begin : g_bad_adr
        $error("ADR_W must lie between 4 and 8");
    end
    if (CLK_HZ < 8 * RC_OSC_NOM_HZ) begin : g_bad_clk
        $error("system clock too slow to sample the RC clock");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        ps_e ps;
        logic [CFG_W-1:0] cfg;
        logic sw_en;
        logic to_flag;
        logic sleep_f;
        logic idle_f;
        logic ack;
        logic [31:0] dat;
        logic dev_rst;
        logic wake;
        logic osc_en;
    } ctrl_s;

    ctrl_s st_r;
    ctrl_s st_nxt;

    logic tick;
    logic run;
    logic expire;
    logic win_open;
    logic [POST_W-1:0] post_cnt;
    logic windowed;
    logic acc;
    logic wr;
    logic hit_cfg;
    logic hit_rc;
    logic hit_cmd;
    logic hit_stat;
    logic cmd_wr;
    logic clr_req;
    logic slp_req;
    logic idle_req;
    logic exit_req;
    logic violation;
    logic wd_rst;
    logic wake_ev;
    logic cnt_clear;
    logic [31:0] rd_data;
    logic [31:0] wmask;
    logic [31:0] cfg_wr;
    logic [31:0] rc_cur;

    // ----------------------------------------------------------------
    // Submodules
    // ----------------------------------------------------------------
    edge_sync u_osc_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(low_power_rc_osc_i),
        .rise_o(tick)
    );

    watchdog_counter u_counter (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .run_i(run),
        .clear_i(cnt_clear),
        .pre_sel_i(st_r.cfg[CFG_PRE_BIT]),
        .post_sel_i(st_r.cfg[CFG_POST_LSB+:4]),
        .win_sel_i(st_r.cfg[CFG_WIN_LSB+:2]),
        .expire_o(expire),
        .win_open_o(win_open),
        .post_cnt_o(post_cnt)
    );

    // ----------------------------------------------------------------
    // Bus decode and events
    // ----------------------------------------------------------------
    assign run = st_r.cfg[CFG_HWON_BIT] | st_r.sw_en; // R12 R13
    assign windowed = ~st_r.cfg[CFG_WIN_OFF_BIT]; // R16
    assign acc = wb_cyc_i & wb_stb_i;
    assign wr = acc & st_r.ack & wb_we_i;
    assign hit_cfg = wb_adr_i == ADR_W'(REG_CFG_OFS);
    assign hit_rc = wb_adr_i == ADR_W'(REG_RC_OFS);
    assign hit_cmd = wb_adr_i == ADR_W'(REG_CMD_OFS);
    assign hit_stat = wb_adr_i == ADR_W'(REG_STAT_OFS);
    assign cmd_wr = wr & hit_cmd & wb_sel_i[0];
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                    {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign cfg_wr = (32'(st_r.cfg) & ~wmask) | (wb_dat_i & wmask);

    assign clr_req = cmd_wr & wb_dat_i[CMD_CLEAR_BIT]
                     & (st_r.ps == PS_RUN); // R08
    assign slp_req = cmd_wr & wb_dat_i[CMD_SLEEP_BIT]
                     & (st_r.ps == PS_RUN);
    assign idle_req = cmd_wr & wb_dat_i[CMD_IDLE_BIT]
                      & ~wb_dat_i[CMD_SLEEP_BIT] & (st_r.ps == PS_RUN);
    assign exit_req = cmd_wr & wb_dat_i[CMD_EXIT_BIT]
                      & (st_r.ps != PS_RUN);
    assign violation = clr_req & windowed & ~win_open; // R21
    assign wd_rst = (expire & (st_r.ps == PS_RUN)) | violation; // R20
    assign wake_ev = expire & (st_r.ps != PS_RUN); // R09 R10
    assign cnt_clear = wd_rst | wake_ev | clr_req | slp_req | idle_req
                       | exit_req | clk_switch_done_i; // R05 R06 R07 R08

    always_comb begin
        rc_cur = '0;
        rc_cur[RC_IDLE_BIT] = st_r.idle_f;
        rc_cur[RC_SLEEP_BIT] = st_r.sleep_f;
        rc_cur[RC_TO_BIT] = st_r.to_flag;
        rc_cur[RC_SWEN_BIT] = st_r.sw_en;
        rd_data = '0;
        if (hit_cfg) begin
            rd_data = 32'(st_r.cfg);
        end else if (hit_rc) begin
            rd_data = rc_cur;
        end else if (hit_stat) begin
            rd_data[STAT_RUN_BIT] = run;
            rd_data[STAT_WIN_BIT] = win_open;
            rd_data[STAT_PS_LSB+:2] = st_r.ps;
            rd_data[STAT_CNT_LSB+:POST_W] = post_cnt;
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = 1'b0;
        st_nxt.dev_rst = 1'b0;
        st_nxt.wake = 1'b0;
        st_nxt.osc_en = run; // R01
        if (acc && !st_r.ack) begin
            st_nxt.ack = 1'b1;
            st_nxt.dat = rd_data;
        end
        if (wr && hit_cfg) begin
            st_nxt.cfg = cfg_wr[CFG_W-1:0];
        end
        if (wr && hit_rc && wb_sel_i[0]) begin
            st_nxt.idle_f = wb_dat_i[RC_IDLE_BIT]; // R11
            st_nxt.sleep_f = wb_dat_i[RC_SLEEP_BIT]; // R11
            st_nxt.to_flag = wb_dat_i[RC_TO_BIT]; // R15
            st_nxt.sw_en = wb_dat_i[RC_SWEN_BIT]; // R13
        end
        case (st_r.ps)
            PS_RUN: begin
                if (slp_req) begin
                    st_nxt.ps = PS_SLEEP;
                    st_nxt.sleep_f = 1'b1;
                end else if (idle_req) begin
                    st_nxt.ps = PS_IDLE;
                    st_nxt.idle_f = 1'b1;
                end
            end
            PS_SLEEP, PS_IDLE: begin
                if (exit_req || wake_ev) begin
                    st_nxt.ps = PS_RUN; // R07
                end
                if (wake_ev) begin
                    st_nxt.wake = 1'b1; // R10
                    st_nxt.to_flag = 1'b1; // R15
                end
            end
            default: begin
                st_nxt.ps = PS_RUN;
            end
        endcase
        if (wd_rst) begin
            st_nxt.dev_rst = 1'b1; // R20 R21
            st_nxt.to_flag = 1'b1; // R15
            st_nxt.sw_en = RC_SWEN_RST; // R14
            st_nxt.ps = PS_RUN;
        end
        if (rst_i) begin
            st_nxt = '0; // R04
            st_nxt.ps = PS_RUN;
            st_nxt.cfg = CFG_RST;
            st_nxt.sw_en = RC_SWEN_RST; // R14
            st_nxt.to_flag = RC_TO_RST;
        end
    end

    always_ff @(posedge clk_i) begin
        st_r <= st_nxt;
    end

    assign wb_dat_o = st_r.dat;
    assign wb_ack_o = st_r.ack;
    assign device_reset_o = st_r.dev_rst;
    assign wake_o = st_r.wake;
    assign low_power_rc_osc_en_o = st_r.osc_en;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    AST_OSC_FORCED: assert property (@(posedge clk_i) // R01
        !rst_i ##1 !rst_i |-> low_power_rc_osc_en_o == $past(run))
        else $error("rc oscillator enable does not follow watchdog enable");

    AST_HW_ON: assert property (@(posedge clk_i) disable iff (rst_i) // R12
        st_r.cfg[CFG_HWON_BIT] && $past(st_r.cfg[CFG_HWON_BIT])
        |-> run && low_power_rc_osc_en_o)
        else $error("always-on watchdog not running");

    AST_SW_RST: assert property (@(posedge clk_i) // R14
        rst_i || wd_rst |=> !st_r.sw_en)
        else $error("software enable survived a reset");

    AST_TO_STICKY: assert property (@(posedge clk_i) disable iff (rst_i) // R15
        st_r.to_flag && !(wr && hit_rc && wb_sel_i[0]) |=> st_r.to_flag)
        else $error("time-out flag cleared without software");

    AST_WAKE: assert property (@(posedge clk_i) disable iff (rst_i) // R10
        wake_ev |=> wake_o && !device_reset_o && st_r.ps == PS_RUN
        ##1 !wake_o)
        else $error("sleep time-out did not give a wake pulse");

    AST_TO_RESET: assert property (@(posedge clk_i) disable iff (rst_i) // R20
        expire && st_r.ps == PS_RUN |=> device_reset_o && st_r.to_flag)
        else $error("run time-out did not reset the device");

    AST_VIOLATION: assert property (@(posedge clk_i) disable iff (rst_i) // R21
        clr_req && windowed && !win_open |=> device_reset_o)
        else $error("early windowed clear not punished");

    AST_OPEN_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i) // R08
        clr_req && (!windowed || win_open) |=> !device_reset_o
        && post_cnt == '0)
        else $error("clear instruction did not restart the count");

    AST_SWITCH_CLR: assert property (@(posedge clk_i) disable iff (rst_i) // R05
        clk_switch_done_i |=> post_cnt == '0)
        else $error("clock switch did not clear the watchdog");

    AST_SLEEP_ENTRY: assert property (@(posedge clk_i) disable iff (rst_i) // R06
        slp_req && !wd_rst |=> st_r.ps == PS_SLEEP && st_r.sleep_f
        && post_cnt == '0)
        else $error("sleep entry did not clear the watchdog");

    AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("bus ack held for two cycles");

endmodule
`default_nettype wire

// ===== windowed_watchdog_timer_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) check(32'(g), 32'(e))
module windowed_watchdog_timer_tb_top
    import watchdog_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic osc = 1'b0;
    logic csw = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic dev_rst;
    logic wake;
    logic osc_en;
    int err_count = 0;
    int checked = 0;
    int rst_cnt = 0;
    int wake_cnt = 0;
    int cycles = 0;
    int b;
    int cl;
    int per;
    logic [31:0] rng = 32'h0000ea5b;
    logic [31:0] r;
    logic [31:0] cfg;
    logic [63:0] e;
    logic [63:0] exp_q[$];

    windowed_watchdog_timer dut (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .low_power_rc_osc_i(osc),
        .clk_switch_done_i(csw),
        .wb_cyc_i(cyc),
        .wb_stb_i(stb),
        .wb_we_i(we),
        .wb_adr_i(adr),
        .wb_sel_i(sel),
        .wb_dat_i(dat),
        .wb_dat_o(rdat),
        .wb_ack_o(ack),
        .device_reset_o(dev_rst),
        .wake_o(wake),
        .low_power_rc_osc_en_o(osc_en)
    );

    // ----------------------------------------------------------------
    // Clocks, monitor and helpers
    // ----------------------------------------------------------------
    always #5 clk_i = ~clk_i;

    always begin
        repeat (4) @(posedge clk_i);
        osc <= ~osc;
    end

    always @(posedge clk_i) begin
        cycles++;
        if (dev_rst === 1'b1) begin
            rst_cnt++;
        end
        if (wake === 1'b1) begin
            wake_cnt++;
        end
        if (ack === 1'b1 && we === 1'b0) begin
            if (exp_q.size() == 0) begin
                `CHK(0, 1);
            end else begin
                e = exp_q.pop_front();
                `CHK(rdat & e[63:32], e[31:0]);
            end
        end
        if (cycles == 30000) begin
            err_count++;
            print_verdict();
        end
    end

    task automatic check(input logic [31:0] g, input logic [31:0] x);
        checked++;
        if (g !== x) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, g, x);
        end
    endtask

    task automatic print_verdict();
        $display("Mismatches %0d, comparisons %0d", err_count, checked);
        if (err_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    // Classic cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        `CHK(n < 20, 1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x,
                      input logic [31:0] m);
        exp_q.push_back({m, x});
        wb(1'b0, a, 32'h0);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Cycles until a reset or wake pulse, bounded by hi
    task automatic wait_pulse(input bit wk, input int lo, input int hi);
        int n;
        int b0;
        n = 0;
        b0 = wk ? wake_cnt : rst_cnt;
        while ((wk ? wake_cnt : rst_cnt) == b0 && n <= hi) begin
            @(posedge clk_i);
            n++;
        end
        `CHK(n >= lo && n <= hi, 1);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(REG_CFG_OFS, 32'(CFG_RST), '1);
        rd(REG_RC_OFS, 32'h0, '1);
        `CHK(osc_en, 0);
        r = xs();
        wr({r[7:4] | 4'h1, 4'h0}, r);
        rd({r[7:4] | 4'h1, 4'h0}, 32'h0, '1);
        rd(REG_RC_OFS, 32'h0, '1);
        for (int i = 0; i < 5; i++) begin
            cfg = {22'h0, 2'b11, 2'b01, 1'b0, 1'(i > 2), 4'(i > 2 ? i - 3 : i)};
            per = 8 * (i > 2 ? 128 : 32) << (i > 2 ? i - 3 : i);
            wr(REG_CFG_OFS, cfg);
            rd(REG_CFG_OFS, cfg, '1);
            wr(REG_RC_OFS, 32'h20);
            wait_pulse(1'b0, per - 12, per + 16);
            rd(REG_RC_OFS, 32'h10, 32'h30);
        end
        wr(REG_RC_OFS, 32'h0);
        rd(REG_RC_OFS, 32'h0, '1);
        wr(REG_CFG_OFS, 32'h340);
        wr(REG_RC_OFS, 32'h20);
        idle(2);
        `CHK(osc_en, 1);
        b = rst_cnt;
        for (int i = 0; i < 6; i++) begin
            r = xs();
            idle(100 + int'(r[6:0]));
            if (i[0]) begin
                @(posedge clk_i);
                csw <= 1'b1;
                @(posedge clk_i);
                csw <= 1'b0;
            end else begin
                wr(REG_CMD_OFS, 32'h1);
            end
        end
        `CHK(rst_cnt, b);
        wait_pulse(1'b0, 244, 272);
        for (int k = 1; k <= 2; k++) begin
            wr(REG_RC_OFS, 32'h20);
            idle(100);
            wr(REG_CMD_OFS, 32'(1 << k));
            b = rst_cnt;
            rd(REG_STAT_OFS, 32'(k << 2), 32'hc);
            rd(REG_RC_OFS, 32'h20 | (32'h10 >> k), '1);
            wait_pulse(1'b1, 232, 272);
            `CHK(rst_cnt, b);
            rd(REG_STAT_OFS, 32'h0, 32'hc);
            rd(REG_RC_OFS, 32'h30 | (32'h10 >> k), '1);
            wr(REG_RC_OFS, 32'h20);
            rd(REG_RC_OFS, 32'h20, '1);
        end
        wr(REG_CMD_OFS, 32'h2);
        idle(150);
        wr(REG_CMD_OFS, 32'h8);
        b = wake_cnt;
        wait_pulse(1'b0, 244, 272);
        `CHK(wake_cnt, b);
        for (int s = 0; s < 4; s++) begin
            cl = s == 3 ? 192 : s == 2 ? 160 : s == 1 ? 128 : 64;
            wr(REG_CFG_OFS, 32'(s << 8));
            wr(REG_RC_OFS, 32'h20);
            idle(cl + 24);
            b = rst_cnt;
            wr(REG_CMD_OFS, 32'h1);
            idle(6);
            `CHK(rst_cnt, b);
            wr(REG_RC_OFS, 32'h0);
            wr(REG_RC_OFS, 32'h20);
            idle(cl - 24);
            wr(REG_CMD_OFS, 32'h1);
            wait_pulse(1'b0, 1, 6);
        end
        wr(REG_CFG_OFS, 32'h3c0);
        wr(REG_RC_OFS, 32'h0);
        idle(2);
        `CHK(osc_en, 1);
        wait_pulse(1'b0, 244, 272);
        idle(100);
        rst_i <= 1'b1;
        idle(2);
        rst_i <= 1'b0;
        rd(REG_CFG_OFS, 32'(CFG_RST), '1);
        rd(REG_RC_OFS, 32'h0, '1);
        rd(REG_STAT_OFS, 32'h0, 32'h7fff0001);
        b = rst_cnt;
        idle(600);
        `CHK(rst_cnt, b);
        `CHK(osc_en, 0);
        print_verdict();
    end
endmodule
`default_nettype wire
